// ==== design/dpdodt_delay_line.sv ====
`timescale 1ns/1ns
`default_nettype none

// variable-length shift line: output is input delayed by lat cycles
module dpdodt_delay_line #(
  parameter int DEPTH = 32,
  parameter int LW    = 5
) (
  input  wire logic          clk,  // command clock
  input  wire logic          nrst, // sync reset, active low
  input  wire logic          din,  // sampled level
  input  wire logic [LW-1:0] lat,  // delay in cycles
  output logic               dout  // delayed level
);

  logic [DEPTH-1:0] line_reg;

  always_ff @(posedge clk)
  begin
    if (!nrst)
      line_reg <= '0;
    else
      line_reg <= {line_reg[DEPTH-2:0], din};
  end

  // zero latency passes the pin straight through
  always_comb
  begin
    if (lat == '0)
      dout = din;
    else
      dout = line_reg[lat - LW'(1)];
  end

endmodule // dpdodt_delay_line

`default_nettype wire

// ==== design/dpdodt_top.sv ====
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none

module dpdodt_top (
  input  wire logic                 clk,            // command clock
  input  wire logic                 nrst,           // sync reset
  input  wire dpdodt_pkg::dpd_cmd_t cmd_in,         // command pins
  input  wire logic                 termination_control_pin, // term pin
  input  wire logic                 self_refresh,   // self-refresh flag
  input  wire logic                 psel,           // apb select
  input  wire logic                 penable,        // apb enable
  input  wire logic                 pwrite,         // apb write
  input  wire logic [7:0]           paddr,          // apb address
  input  wire logic [31:0]          pwdata,         // apb write data
  output logic [31:0]               prdata,         // apb read data
  output logic                      pready,         // apb ready
  output logic                      pslverr,        // apb error
  output dpdodt_pkg::dpd_status_t   status,         // live status
  output logic                      termination_resistance // term on
);

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  logic [15:0] mode_register_zero_reg;
  logic [15:0] mode_register_one_reg;
  logic [15:0] mode_register_two_reg;
  logic [7:0]  bank_cfg_reg;
  logic [31:0] prdata_next;
  logic        apb_access;

  function automatic logic addr_known(input logic [7:0] a);
    return a == dpdodt_pkg::ADDR_MODE0 || a == dpdodt_pkg::ADDR_MODE1 ||
           a == dpdodt_pkg::ADDR_MODE2 || a == dpdodt_pkg::ADDR_STATUS ||
           a == dpdodt_pkg::ADDR_CFG;
  endfunction

  assign apb_access = psel && penable;
  assign pready     = 1'b1;
  assign pslverr    = apb_access && !addr_known(paddr);

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      mode_register_zero_reg <= dpdodt_pkg::MODE0_RESET;
      mode_register_one_reg  <= dpdodt_pkg::MODE1_RESET;
      mode_register_two_reg  <= dpdodt_pkg::MODE2_RESET;
    end
    else if (apb_access && pwrite)
    begin
      case (paddr)
        dpdodt_pkg::ADDR_MODE0: mode_register_zero_reg <= pwdata[15:0];
        dpdodt_pkg::ADDR_MODE1: mode_register_one_reg  <= pwdata[15:0];
        dpdodt_pkg::ADDR_MODE2: mode_register_two_reg  <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // bank tracking: one open flag per bank
  // ----------------------------------------------------------------
  logic [7:0] bank_open_reg;
  logic       cmd_live;
  logic       is_nop;

  always_comb
  begin
    is_nop = cmd_in.cmd == dpdodt_pkg::CMD_NOP ||
             cmd_in.cmd[3] == 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      bank_cfg_reg <= dpdodt_pkg::CFG_RESET;
    else if (apb_access && pwrite && paddr == dpdodt_pkg::ADDR_CFG)
      bank_cfg_reg <= pwdata[7:0];
    else if (cmd_live)
    begin
      case (cmd_in.cmd)
        dpdodt_pkg::CMD_ACT: bank_cfg_reg[cmd_in.bank] <= 1'b1;
        dpdodt_pkg::CMD_PRE:
          if (cmd_in.ap)
            bank_cfg_reg <= '0;
          else
            bank_cfg_reg[cmd_in.bank] <= 1'b0;
        default: ;
      endcase
    end
  end
  assign bank_open_reg = bank_cfg_reg;

  // ----------------------------------------------------------------
  // power-down state machine
  // ----------------------------------------------------------------
  dpdodt_pkg::dpd_state_t state_reg;
  logic [9:0] cnt_reg;
  logic       dll_on_reg;
  logic       dll_locked_reg;
  logic [9:0] lock_cnt_reg;
  logic       slow_exit_reg;
  logic       buffers_off;
  logic       ca_off;

  // command receivers stay on only outside power-down
  assign cmd_live = cmd_in.reset_n &&
    (state_reg == dpdodt_pkg::DPD_ACTIVE ||
     state_reg == dpdodt_pkg::DPD_EXIT);

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state_reg     <= dpdodt_pkg::DPD_RESET;
      slow_exit_reg <= 1'b0;
    end
    else if (!cmd_in.reset_n)
      state_reg <= dpdodt_pkg::DPD_RESET;
    else
    begin
      case (state_reg)
        dpdodt_pkg::DPD_RESET:
          state_reg <= dpdodt_pkg::DPD_ACTIVE;
        dpdodt_pkg::DPD_ACTIVE, dpdodt_pkg::DPD_EXIT:
          if (!cmd_in.clock_enable && is_nop)
            state_reg <= dpdodt_pkg::DPD_PD_ENTRY;
          else if (state_reg == dpdodt_pkg::DPD_EXIT &&
                   cnt_reg == '0)
            state_reg <= dpdodt_pkg::DPD_ACTIVE;
        dpdodt_pkg::DPD_PD_ENTRY:
          // row operations already logged finish here first
          if (cnt_reg == '0)
          begin
            if (bank_open_reg != '0)
              state_reg <= dpdodt_pkg::DPD_PD_ACTIVE;
            else
              state_reg <= dpdodt_pkg::DPD_PD_PRECHARGE;
            slow_exit_reg <= bank_open_reg == '0 &&
              !mode_register_zero_reg[dpdodt_pkg::MODE0_DLL_CTRL_BIT];
          end
        dpdodt_pkg::DPD_PD_ACTIVE, dpdodt_pkg::DPD_PD_PRECHARGE:
          if (cmd_in.clock_enable)
            state_reg <= dpdodt_pkg::DPD_EXIT;
        default:
          state_reg <= dpdodt_pkg::DPD_RESET;
      endcase
    end
  end

  // entry delay and exit latency counter
  always_ff @(posedge clk)
  begin
    if (!nrst)
      cnt_reg <= '0;
    else if (state_reg != dpdodt_pkg::DPD_PD_ENTRY &&
             !cmd_in.clock_enable && is_nop &&
             (state_reg == dpdodt_pkg::DPD_ACTIVE ||
              state_reg == dpdodt_pkg::DPD_EXIT))
      cnt_reg <= 10'(dpdodt_pkg::ENTRY_DELAY_CYC - 1);
    else if ((state_reg == dpdodt_pkg::DPD_PD_ACTIVE ||
              state_reg == dpdodt_pkg::DPD_PD_PRECHARGE) &&
             cmd_in.clock_enable)
      cnt_reg <= slow_exit_reg ?
        10'(dpdodt_pkg::DLL_EXIT_LAT_CYC) :
        10'(dpdodt_pkg::EXIT_LAT_CYC);
    else if (cnt_reg != '0)
      cnt_reg <= cnt_reg - 10'd1;
  end

  // dll: off in reset and in slow-exit precharge power-down, relocks after
  always_ff @(posedge clk)
  begin
    if (!nrst || !cmd_in.reset_n)
    begin
      dll_on_reg     <= 1'b0;
      dll_locked_reg <= 1'b0;
      lock_cnt_reg   <= '0;
    end
    else if (state_reg == dpdodt_pkg::DPD_PD_PRECHARGE && slow_exit_reg)
    begin
      dll_on_reg     <= 1'b0;
      dll_locked_reg <= 1'b0;
      lock_cnt_reg   <= '0;
    end
    else
    begin
      dll_on_reg <= 1'b1;
      if (lock_cnt_reg == 10'(dpdodt_pkg::DLL_LOCK_CYC - 1))
        dll_locked_reg <= 1'b1;
      else
        lock_cnt_reg <= lock_cnt_reg + 10'd1;
    end
  end

  always_comb
  begin
    buffers_off = state_reg == dpdodt_pkg::DPD_PD_ENTRY ||
                  state_reg == dpdodt_pkg::DPD_PD_ACTIVE ||
                  state_reg == dpdodt_pkg::DPD_PD_PRECHARGE;
    ca_off = state_reg == dpdodt_pkg::DPD_PD_ACTIVE ||
             state_reg == dpdodt_pkg::DPD_PD_PRECHARGE;
  end

  // ----------------------------------------------------------------
  // termination control
  // ----------------------------------------------------------------
  localparam int    LAT_W = dpdodt_pkg::LAT_W;
  logic             term_enabled;
  logic             sync_mode;
  logic             term_delayed;
  logic [LAT_W-1:0] term_lat;

  always_comb
  begin
    term_enabled =
      mode_register_one_reg[dpdodt_pkg::MODE1_NOM_B0] ||
      mode_register_one_reg[dpdodt_pkg::MODE1_NOM_B1] ||
      mode_register_one_reg[dpdodt_pkg::MODE1_NOM_B2] ||
      mode_register_two_reg[dpdodt_pkg::MODE2_WR_B0] ||
      mode_register_two_reg[dpdodt_pkg::MODE2_WR_B1];
    sync_mode = dll_on_reg && dll_locked_reg;
    term_lat = LAT_W'(dpdodt_pkg::CWL_BASE) +
      LAT_W'(mode_register_two_reg[dpdodt_pkg::MODE2_CWL_LO +: 3]) +
      LAT_W'(mode_register_one_reg[dpdodt_pkg::MODE1_AL_LO +: 2]) -
      LAT_W'(dpdodt_pkg::TERM_LAT_OFFSET);
  end

  // the pin alone drives the decision; no command decode here
  dpdodt_delay_line #(
    .DEPTH (dpdodt_pkg::TERM_PIPE_DEPTH),
    .LW    (LAT_W)
  ) u_term_delay (
    .clk   (clk),
    .nrst  (nrst),
    .din   (termination_control_pin),
    .lat   (term_lat),
    .dout  (term_delayed)
  );

  always_ff @(posedge clk)
  begin
    if (!nrst)
      termination_resistance <= 1'b0;
    else if (self_refresh || !term_enabled)
      termination_resistance <= 1'b0;
    else if (sync_mode)
      termination_resistance <= term_delayed;
    else
      termination_resistance <= termination_control_pin;
  end

  // ----------------------------------------------------------------
  // status and read data
  // ----------------------------------------------------------------
  always_comb
  begin
    status.in_powerdown     = buffers_off;
    status.precharge_pd     = state_reg == dpdodt_pkg::DPD_PD_PRECHARGE;
    status.dll_on           = dll_on_reg;
    status.dll_locked       = dll_locked_reg;
    status.buffers_off      = buffers_off;
    status.ca_receivers_off = ca_off;
    status.term_enabled     = term_enabled;
    status.term_active      = termination_resistance;
    status.sync_mode        = sync_mode;
    status.exit_ready       = state_reg == dpdodt_pkg::DPD_ACTIVE;
    status.dll_exit_ready   = state_reg == dpdodt_pkg::DPD_ACTIVE &&
                              dll_locked_reg;
    case (paddr)
      dpdodt_pkg::ADDR_MODE0:  prdata_next = {16'h0000, mode_register_zero_reg};
      dpdodt_pkg::ADDR_MODE1:  prdata_next = {16'h0000, mode_register_one_reg};
      dpdodt_pkg::ADDR_MODE2:  prdata_next = {16'h0000, mode_register_two_reg};
      dpdodt_pkg::ADDR_STATUS: prdata_next = {21'h00_0000, status};
      dpdodt_pkg::ADDR_CFG:    prdata_next = {24'h00_0000, bank_cfg_reg};
      default:                 prdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= prdata_next;
  end

endmodule // dpdodt_top

`default_nettype wire

// ==== include/dpdodt_pkg.sv ====
`default_nettype none

package dpdodt_pkg;

  // ----------------------------------------------------------------
  // command encodings (cs_n, ras_n, cas_n, we_n)
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_DESELECT = 4'h8;
  localparam logic [3:0] CMD_NOP      = 4'h7;
  localparam logic [3:0] CMD_ACT      = 4'h3;
  localparam logic [3:0] CMD_PRE      = 4'h2;
  localparam logic [3:0] CMD_REF      = 4'h1;
  localparam logic [3:0] CMD_MRS      = 4'h0;
  localparam logic [3:0] CMD_RD       = 4'h5;
  localparam logic [3:0] CMD_WR       = 4'h4;

  // ----------------------------------------------------------------
  // apb register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE0  = 8'h00;
  localparam logic [7:0] ADDR_MODE1  = 8'h04;
  localparam logic [7:0] ADDR_MODE2  = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_CFG    = 8'h10;

  // mode register field positions
  localparam int MODE0_DLL_CTRL_BIT = 12;
  localparam int MODE1_NOM_B0       = 2;
  localparam int MODE1_NOM_B1       = 6;
  localparam int MODE1_NOM_B2       = 9;
  localparam int MODE1_AL_LO        = 3;
  localparam int MODE2_CWL_LO       = 3;
  localparam int MODE2_WR_B0        = 9;
  localparam int MODE2_WR_B1        = 10;

  // reset values
  localparam logic [15:0] MODE0_RESET = 16'h0000;
  localparam logic [15:0] MODE1_RESET = 16'h0000;
  localparam logic [15:0] MODE2_RESET = 16'h0000;
  localparam logic [7:0]  CFG_RESET   = 8'h00;

  // ----------------------------------------------------------------
  // timing in cycles and latency width
  // ----------------------------------------------------------------
  localparam int CWL_BASE           = 5;
  localparam int TERM_LAT_OFFSET    = 2;
  localparam int ENTRY_DELAY_CYC    = 1;
  localparam int EXIT_LAT_CYC       = 3;
  localparam int DLL_EXIT_LAT_CYC   = 10;
  localparam int DLL_LOCK_CYC       = 512;
  localparam int LAT_W              = 5;
  localparam int TERM_PIPE_DEPTH    = 32;

  typedef enum logic [2:0] {
    DPD_ACTIVE,
    DPD_PD_ENTRY,
    DPD_PD_ACTIVE,
    DPD_PD_PRECHARGE,
    DPD_EXIT,
    DPD_RESET
  } dpd_state_t;

  typedef struct packed {
    logic       clock_enable;
    logic [3:0] cmd;
    logic [2:0] bank;
    logic       ap;
    logic       reset_n;
  } dpd_cmd_t;

  typedef struct packed {
    logic       in_powerdown;
    logic       precharge_pd;
    logic       dll_on;
    logic       dll_locked;
    logic       buffers_off;
    logic       ca_receivers_off;
    logic       term_enabled;
    logic       term_active;
    logic       sync_mode;
    logic       exit_ready;
    logic       dll_exit_ready;
  } dpd_status_t;

endpackage

`default_nettype wire

// ==== verif/dpdodt_ctrl_model.sv ====
`timescale 1ns/1ns
`default_nettype none

module dpdodt_ctrl_model #(
  parameter int MIN_PULSE = 3 // minimum clock-enable pulse, cycles
) (
  input  wire logic            clk,      // command clock
  output dpdodt_pkg::dpd_cmd_t cmd,      // command pins
  output logic                 term_pin  // termination pin
);
  initial
  begin
    cmd = {1'b1, dpdodt_pkg::CMD_NOP, 3'h0, 1'b0, 1'b1};
    term_pin = 1'b0;
  end
  // no entry during bursts, mode writes or dll locking: the bench
  // waits for lock first
  task automatic drive(input logic ke, input logic [3:0] c,
    input logic [2:0] b, input logic ap, input logic rn);
    @(posedge clk);
    cmd <= {ke, c, b, ap, rn};
    #1;
  endtask
  task automatic set_term(input logic v);
    @(posedge clk);
    term_pin <= v;
  endtask
  task automatic nops(input int k);
    repeat (k) drive(1'b1, dpdodt_pkg::CMD_NOP, 3'h0, 1'b0, 1'b1);
  endtask
  // nops cover the entry delay; low held past the minimum pulse
  task automatic enter();
    repeat (MIN_PULSE + 1)
      drive(1'b0, dpdodt_pkg::CMD_NOP, 3'h0, 1'b0, 1'b1);
  endtask
  task automatic leave();
    nops(dpdodt_pkg::DLL_EXIT_LAT_CYC + 1);
  endtask
endmodule // dpdodt_ctrl_model

`default_nettype wire

// ==== verif/dpdodt_top_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none

module dpdodt_checker (
  input wire logic                    clk,     // command clock
  input wire logic                    nrst,    // sync reset
  input wire dpdodt_pkg::dpd_cmd_t    cmd_in,  // command pins
  input wire logic                    termination_control_pin, // pin
  input wire logic                    self_refresh, // self-refresh
  input wire dpdodt_pkg::dpd_status_t status,  // live status
  input wire logic                    termination_resistance // term on
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  logic       idle;
  logic [4:0] low_cnt;
  assign idle = cmd_in.cmd == dpdodt_pkg::CMD_NOP
    || cmd_in.cmd == dpdodt_pkg::CMD_DESELECT;

  // 31 low cycles outlast the longest latency the mode fields allow
  always_ff @(posedge clk)
  begin
    if (!nrst || termination_control_pin)
      low_cnt <= 5'h0;
    else if (low_cnt != 5'h1f)
      low_cnt <= low_cnt + 5'h1;
  end

  property p_entry;
    !cmd_in.clock_enable && idle && cmd_in.reset_n && !status.in_powerdown
      |-> ##[1:3] status.in_powerdown;
  endproperty
  a_entry: assert property (p_entry)
    else $error("power-down not entered");
  property p_exit;
    status.in_powerdown && cmd_in.clock_enable && idle && cmd_in.reset_n
      |-> ##[1:3] !status.in_powerdown;
  endproperty
  a_exit: assert property (p_exit)
    else $error("power-down not left");
  property p_hold;
    status.in_powerdown && !cmd_in.clock_enable && cmd_in.reset_n
      |=> status.in_powerdown;
  endproperty
  a_hold: assert property (p_hold)
    else $error("power-down left while clock-enable low");
  property p_rst;
    status.in_powerdown && !cmd_in.reset_n |=> !status.in_powerdown;
  endproperty
  a_rst: assert property (p_rst)
    else $error("reset did not end power-down");
  property p_dll;
    status.ca_receivers_off && !status.precharge_pd |-> status.dll_on;
  endproperty
  a_dll: assert property (p_dll)
    else $error("dll off in active power-down");
  property p_rcv;
    // receivers may only drop once power-down has already stood a cycle
    status.ca_receivers_off |-> status.buffers_off &&
      $past(status.in_powerdown);
  endproperty
  a_rcv: assert property (p_rcv)
    else $error("receivers off outside power-down");
  property p_sr;
    self_refresh |=> !termination_resistance;
  endproperty
  a_sr: assert property (p_sr)
    else $error("termination on in self-refresh");
  property p_dis;
    !status.term_enabled |=> !termination_resistance;
  endproperty
  a_dis: assert property (p_dis)
    else $error("termination on while disabled");
  property p_low;
    low_cnt == 5'h1f |-> !termination_resistance;
  endproperty
  a_low: assert property (p_low)
    else $error("termination on with pin low");

  c_entry: cover property ($rose(status.in_powerdown));
  c_term: cover property ($rose(termination_resistance));
  c_slow: cover property (status.in_powerdown && !status.dll_on);
endmodule // dpdodt_checker

bind dpdodt_top dpdodt_checker u_chk (
  .clk(clk), .nrst(nrst), .cmd_in(cmd_in),
  .termination_control_pin(termination_control_pin),
  .self_refresh(self_refresh), .status(status),
  .termination_resistance(termination_resistance)
);

`default_nettype wire

// ==== verif/test_dram_powerdown_odt_control.sv ====
`timescale 1ns/1ns
`default_nettype none

module test_dram_powerdown_odt_control;
  logic                    clk;
  logic                    nrst;
  logic                    sr;
  logic                    psel;
  logic                    penable;
  logic                    pwrite;
  logic [7:0]              paddr;
  logic [31:0]             pwdata;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  logic                    term_on;
  logic                    tpin;
  logic [31:0]             rd;
  logic                    rerr;
  dpdodt_pkg::dpd_cmd_t    cmd;
  dpdodt_pkg::dpd_status_t st;
  int                      err_total;
  int                      n_compared;
  int                      n;
  logic [7:0]              ta [5] = '{8'h04, 8'h04, 8'h04, 8'h08, 8'h08};
  int                      tb [5] = '{2, 6, 9, 9, 10};

  dpdodt_top u_dut (
    .clk(clk), .nrst(nrst), .cmd_in(cmd),
    .termination_control_pin(tpin), .self_refresh(sr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .status(st), .termination_resistance(term_on)
  );
  dpdodt_ctrl_model u_ctl (.clk(clk), .cmd(cmd), .term_pin(tpin));

  initial clk = 1'b0;
  always #20 clk = ~clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic lat(input logic v, input int exp);
    u_ctl.set_term(v);
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (term_on !== v && n < 40);
    chk(n, exp);
  endtask
  task automatic wait_lock();
    n = 0;
    while (st.dll_locked !== 1'b1 && n < 700)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(st.dll_locked, 1'b1);
  endtask
  task automatic report_and_stop();
    $display("compared %0d, mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (6000) @(posedge clk);
    err_total++;
    report_and_stop();
  end

  initial
  begin
    nrst = 1'b0;
    sr = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, dpdodt_pkg::ADDR_MODE0, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(term_on, 1'b0);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk({rerr, rd[30:0]}, 32'h8000_0000);
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b1, ta[i], 32'h0000_0001 << tb[i]);
      chk(st.term_enabled, 1'b1);
      apb(1'b1, ta[i], 32'h0000_0000);
      chk(st.term_enabled, 1'b0);
    end
    apb(1'b1, dpdodt_pkg::ADDR_MODE1, 32'h0000_0004);
    lat(1'b1, 1);
    lat(1'b0, 1);
    wait_lock();
    chk(st.sync_mode, 1'b1);
    lat(1'b1, 4);
    lat(1'b0, 4);
    apb(1'b1, dpdodt_pkg::ADDR_MODE2, 32'h0000_0008);
    lat(1'b1, 5);
    lat(1'b0, 5);
    u_ctl.drive(1'b1, dpdodt_pkg::CMD_WR, 3'h0, 1'b0, 1'b1);
    u_ctl.nops(8);
    chk(term_on, 1'b0);
    lat(1'b1, 5);
    u_ctl.drive(1'b1, dpdodt_pkg::CMD_RD, 3'h0, 1'b0, 1'b1);
    u_ctl.nops(8);
    chk(term_on, 1'b1);
    @(posedge clk);
    sr <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(term_on, 1'b0);
    u_ctl.set_term(1'b0);
    sr <= 1'b0;
    apb(1'b1, dpdodt_pkg::ADDR_MODE0, 32'h0000_1000);
    u_ctl.drive(1'b1, dpdodt_pkg::CMD_PRE, 3'h0, 1'b1, 1'b1);
    u_ctl.enter();
    chk({st.precharge_pd, st.dll_on}, 2'b11);
    u_ctl.leave();
    chk(st.in_powerdown, 1'b0);
    chk(st.exit_ready, 1'b1);
    apb(1'b1, dpdodt_pkg::ADDR_MODE0, 32'h0000_0000);
    u_ctl.enter();
    chk({st.precharge_pd, st.dll_on}, 2'b10);
    chk({st.buffers_off, st.ca_receivers_off}, 2'b11);
    u_ctl.leave();
    chk(st.in_powerdown, 1'b0);
    chk({st.exit_ready, st.dll_exit_ready}, 2'b00);
    wait_lock();
    chk(st.dll_exit_ready, 1'b1);
    u_ctl.drive(1'b1, dpdodt_pkg::CMD_ACT, 3'h2, 1'b0, 1'b1);
    u_ctl.nops(2);
    u_ctl.enter();
    chk({st.precharge_pd, st.dll_on}, 2'b01);
    u_ctl.drive(1'b0, dpdodt_pkg::CMD_ACT, 3'h5, 1'b0, 1'b1);
    u_ctl.drive(1'b0, dpdodt_pkg::CMD_NOP, 3'h0, 1'b0, 1'b0);
    chk(st.in_powerdown, 1'b1);
    u_ctl.nops(1);
    chk(st.in_powerdown, 1'b0);
    apb(1'b0, dpdodt_pkg::ADDR_CFG, 32'h0000_0000);
    chk(rd, 32'h0000_0004);
    report_and_stop();
  end
endmodule // test_dram_powerdown_odt_control

`default_nettype wire
